// ---- pkg/smc_pkg.sv ----
// Shared constants, types and register map of the supply mode controller.
// Contract
// - Wake timer period selectable 10 ms to 2 s.
// - Supply on in Normal, Stop, Restart only.
// - Buck PWM in Normal, Restart, Stop after switch.
// - PWM allows full duty at low input.
// - Stop entry switches buck to PFM.
// - Soft start at power-up and into Restart from Sleep or Fail-Safe.
// - Soft start ramps duty in held steps.
// - Status reports buck node faults and band.
// - Status bits never change mode or configuration.
// - Status reports boost pin faults, ground loss.
// - Boost enable only in Normal or Stop; a set enable bit still runs the boost in Restart.
// - Select bit picks threshold and hysteresis pair.
// - Boost on below threshold, off above hysteresis.
// - Active flag clears only above threshold.
// - Boost runs fixed-frequency PWM only.
// - Stop overload forces PWM, event, flag.
// - Stop command returns buck to PFM.
// - Allow bit zero disables automatic transition.
// - Wake pin selects modulation when enabled.
package smc_pkg;

  // Register byte addresses.
  localparam logic [7:0] SMC_ADDR_TIMER  = 8'h00;
  localparam logic [7:0] SMC_ADDR_HWCTL  = 8'h04;
  localparam logic [7:0] SMC_ADDR_MODE   = 8'h08;
  localparam logic [7:0] SMC_ADDR_STAT   = 8'h0c;
  localparam logic [7:0] SMC_ADDR_WKSTAT = 8'h10;
  localparam logic [7:0] SMC_ADDR_SSTAT  = 8'h14;

  ////////////////////////////////////////////////////////////////////////////////
  // System modes as reported by the mode controller.
  typedef enum logic [2:0] {
    SMC_NORMAL   = 3'b000,
    SMC_STOP     = 3'b001,
    SMC_RESTART  = 3'b010,
    SMC_SLEEP    = 3'b011,
    SMC_FAILSAFE = 3'b100
  } smc_mode_type;

  // Soft start sequencer states.
  typedef enum logic [0:0] {
    SMC_SS_IDLE = 1'b0,
    SMC_SS_RAMP = 1'b1
  } smc_ss_type;

  ////////////////////////////////////////////////////////////////////////////////
  // Hardware control fields and reset value.
  localparam int         SMC_HW_BOOST_EN  = 0;
  localparam int         SMC_HW_BOOST_SEL = 1;
  localparam int         SMC_HW_AUTO_OK   = 2;
  localparam int         SMC_HW_WAKE_MOD  = 3;
  localparam logic [3:0] SMC_HW_RESET     = 4'h4;

  // Wake timer control fields.
  localparam int         SMC_TMR_EN       = 3;
  localparam logic [3:0] SMC_TMR_RESET    = 4'h0;

  // Regulator status bit positions.
  localparam int SMC_ST_FAULTS = 6;
  localparam int SMC_ST_ACT    = 6;
  localparam int SMC_ST_RUN    = 7;
  localparam int SMC_WK_AUTO   = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int SMC_CLK_HZ        = 25_000_000;
  localparam int SMC_CLK_NS        = 40;
  localparam int SMC_MS_CYCLES     = SMC_CLK_HZ / 1000;
  localparam int SMC_SW_PERIOD_NS  = 2500;
  localparam int SMC_SW_CYC        = SMC_SW_PERIOD_NS / SMC_CLK_NS;
  localparam logic [10:0] SMC_P10MS   = 11'h00a;
  localparam logic [10:0] SMC_P20MS   = 11'h014;
  localparam logic [10:0] SMC_P50MS   = 11'h032;
  localparam logic [10:0] SMC_P100MS  = 11'h064;
  localparam logic [10:0] SMC_P200MS  = 11'h0c8;
  localparam logic [10:0] SMC_P1000MS = 11'h3e8;
  localparam logic [10:0] SMC_P2000MS = 11'h7d0;

  // Soft start ramp shape.
  localparam logic [3:0] SMC_SS_HOLD = 4'h8;
  localparam logic [7:0] SMC_SS_MIN  = 8'h08;
  localparam logic [7:0] SMC_SS_STEP = 8'h08;
  localparam logic [7:0] SMC_SS_FULL = 8'hff;

endpackage

// ---- src/smc_soft_start.sv ----
// Buck soft start duty ramp sequencer.
`timescale 1ns/1ns
`default_nettype none
module smc_soft_start
  import smc_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       start,
  input  wire logic       sw_tick,
  input  wire logic       target_reached,
  output logic            active,
  output logic [7:0]      duty
);

  smc_ss_type state;
  logic [3:0] hold;

  ////////////////////////////////////////////////////////////////////////////////
  // Start at minimum duty, hold for some periods, then step up until the rail is reached.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state  <= SMC_SS_IDLE;
      hold   <= 4'h0;
      duty   <= 8'h00;
      active <= 1'b0;
    end else begin
      case (state)
        SMC_SS_IDLE: begin
          if (start) begin
            state  <= SMC_SS_RAMP;
            duty   <= SMC_SS_MIN;
            hold   <= 4'h0;
            active <= 1'b1;
          end
        end
        SMC_SS_RAMP: begin
          if (target_reached) begin
            state  <= SMC_SS_IDLE; // Hand over to the regulation loop.
            active <= 1'b0;
          end else if (sw_tick) begin
            if (hold == SMC_SS_HOLD - 4'h1) begin
              hold <= 4'h0;
              // Saturate so a rail that never arrives leaves the duty at full.
              duty <= (duty > SMC_SS_FULL - SMC_SS_STEP) ? SMC_SS_FULL : duty + SMC_SS_STEP;
            end else begin
              hold <= hold + 4'h1;
            end
          end
        end
        default: begin
          state  <= SMC_SS_IDLE;
          active <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- src/smc_top.sv ----
// Supply mode controller: mode gating, buck modulation, soft start, boost hysteresis, status.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module smc_top
  import smc_pkg::*;
#(
  parameter int MS_DIV = SMC_MS_CYCLES
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  sys_mode,
  input  wire logic        buck_load_high,
  input  wire logic        buck_target_reached,
  input  wire logic        wake_input_pin,
  input  wire logic        sense_below_th1,
  input  wire logic        sense_above_hys1,
  input  wire logic        sense_below_th2,
  input  wire logic        sense_above_hys2,
  input  wire logic        buck_node_open,
  input  wire logic        buck_node_short,
  input  wire logic        buck_out_of_band,
  input  wire logic        boost_pin_open,
  input  wire logic        boost_pin_short,
  input  wire logic        boost_gnd_lost,
  output logic             smps_enable,
  output logic             buck_pwm,
  output logic             buck_full_duty_allow,
  output logic [7:0]       buck_duty,
  output logic             soft_start_active,
  output logic             boost_run,
  output logic             step_up_active_flag,
  output logic             auto_transition_event,
  output logic             wake_timer_tick
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.
  smc_mode_type mode;
  smc_mode_type mode_q;
  logic [3:0]   sense_raw;
  logic [3:0]   sense_s1;
  logic [3:0]   sense_s2;
  logic [5:0]   fault_raw;
  logic [5:0]   fault_flag;
  logic [3:0]   wake_timer_control;
  logic [3:0]   hardware_control;
  logic         auto_transition_flag;
  logic         auto_pwm;
  logic         powered_up;
  logic         ss_start;
  logic         sw_tick;
  logic [7:0]   sw_cnt;
  logic         ms_tick;
  logic [15:0]  ms_cnt;
  logic [10:0]  tmr_cnt;
  logic [10:0]  tmr_period;
  logic         supply_mode;
  logic         boost_mode;
  logic         boost_ok;
  logic         below_sel;
  logic         above_sel;
  logic         setup;
  logic         wr_en;
  logic         hit;
  logic [31:0]  rd_mux;
  logic         stop_cmd;
  logic         stop_entry;
  logic         auto_hit;
  logic         next_pwm;

  assign mode = smc_mode_type'(sys_mode);

  ////////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers on the supply-sense comparators; only stage two is used.
  assign sense_raw = {sense_above_hys2, sense_below_th2, sense_above_hys1, sense_below_th1};

  generate
    for (genvar i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sense_s1[i] <= 1'b0;
          sense_s2[i] <= 1'b0;
        end else begin
          sense_s1[i] <= sense_raw[i];
          sense_s2[i] <= sense_s1[i];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Mode decode.
  always_comb begin
    supply_mode = (mode == SMC_NORMAL) || (mode == SMC_STOP) || (mode == SMC_RESTART);
    boost_mode  = (mode == SMC_NORMAL) || (mode == SMC_STOP);
  end

  // Previous mode and power-up marker for transition detection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q     <= SMC_SLEEP;
      powered_up <= 1'b0;
    end else begin
      mode_q     <= mode;
      powered_up <= 1'b1;
    end
  end

  assign stop_entry = (mode == SMC_STOP) && (mode_q != SMC_STOP);
  // Power-up, Sleep to Restart and Fail-Safe to Restart launch a soft start.
  assign ss_start = !powered_up ||
                    ((mode == SMC_RESTART) && ((mode_q == SMC_SLEEP) || (mode_q == SMC_FAILSAFE)));

  ////////////////////////////////////////////////////////////////////////////////
  // Switching period and millisecond enables from dividers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_cnt  <= 8'h00;
      sw_tick <= 1'b0;
    end else begin
      sw_tick <= (sw_cnt == 8'(SMC_SW_CYC - 1));
      sw_cnt  <= (sw_cnt == 8'(SMC_SW_CYC - 1)) ? 8'h00 : sw_cnt + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt  <= 16'h0000;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (ms_cnt == 16'(MS_DIV - 1));
      ms_cnt  <= (ms_cnt == 16'(MS_DIV - 1)) ? 16'h0000 : ms_cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Wake timer: period selected by the low field; codes outside the set stop the timer.
  always_comb begin
    case (wake_timer_control[2:0])
      3'h0:    tmr_period = SMC_P10MS;
      3'h1:    tmr_period = SMC_P20MS;
      3'h2:    tmr_period = SMC_P50MS;
      3'h3:    tmr_period = SMC_P100MS;
      3'h4:    tmr_period = SMC_P200MS;
      3'h5:    tmr_period = SMC_P1000MS;
      3'h6:    tmr_period = SMC_P2000MS;
      default: tmr_period = 11'h000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_cnt         <= 11'h000;
      wake_timer_tick <= 1'b0;
    end else begin
      wake_timer_tick <= 1'b0;
      if (!wake_timer_control[SMC_TMR_EN] || (tmr_period == 11'h000) || !boost_mode) begin
        tmr_cnt <= 11'h000;
      end else if (ms_tick) begin
        if (tmr_cnt >= tmr_period - 11'h001) begin
          tmr_cnt         <= 11'h000;
          wake_timer_tick <= 1'b1;
        end else begin
          tmr_cnt <= tmr_cnt + 11'h001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, answer registered from the setup cycle.
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;

  always_comb begin
    hit    = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      SMC_ADDR_TIMER:  rd_mux[3:0] = wake_timer_control;
      SMC_ADDR_HWCTL:  rd_mux[3:0] = hardware_control;
      SMC_ADDR_MODE:   rd_mux[2:0] = mode;
      SMC_ADDR_STAT:   rd_mux[7:0] = {boost_run, step_up_active_flag, fault_flag};
      SMC_ADDR_WKSTAT: rd_mux[SMC_WK_AUTO] = auto_transition_flag;
      SMC_ADDR_SSTAT:  rd_mux[9:0] = {buck_pwm, soft_start_active, buck_duty};
      default:         hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !hit;
      prdata  <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers. Boost enable is accepted only in Normal or Stop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_timer_control <= SMC_TMR_RESET;
      hardware_control   <= SMC_HW_RESET;
    end else if (wr_en) begin
      if (paddr == SMC_ADDR_TIMER) begin
        wake_timer_control <= pwdata[3:0];
      end
      if (paddr == SMC_ADDR_HWCTL) begin
        hardware_control[3:1] <= pwdata[3:1];
        if (boost_mode) begin
          hardware_control[SMC_HW_BOOST_EN] <= pwdata[SMC_HW_BOOST_EN];
        end
      end
    end
  end

  // A Stop code written to the mode register re-arms PFM.
  assign stop_cmd = wr_en && (paddr == SMC_ADDR_MODE) && (pwdata[2:0] == SMC_STOP);

  ////////////////////////////////////////////////////////////////////////////////
  // Regulator status: sticky, write one to clear, a new fault wins over the clear.
  // Nothing here feeds mode or configuration, so faults only inform software.
  assign fault_raw = {boost_gnd_lost, boost_pin_short, boost_pin_open,
                      buck_out_of_band, buck_node_short, buck_node_open};

  generate
    for (genvar f = 0; f < SMC_ST_FAULTS; f++) begin : g_fault
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          fault_flag[f] <= 1'b0;
        end else begin
          fault_flag[f] <= fault_raw[f] ||
                           (fault_flag[f] && !(wr_en && (paddr == SMC_ADDR_STAT) && pwdata[f]));
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Boost hysteresis on the selected threshold pair; the boost itself only runs PWM.
  always_comb begin
    boost_ok  = hardware_control[SMC_HW_BOOST_EN] && supply_mode;
    below_sel = hardware_control[SMC_HW_BOOST_SEL] ? sense_s2[0] : sense_s2[2];
    above_sel = hardware_control[SMC_HW_BOOST_SEL] ? sense_s2[1] : sense_s2[3];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boost_run <= 1'b0;
    end else if (!boost_ok) begin
      boost_run <= 1'b0;
    end else if (below_sel) begin
      boost_run <= 1'b1;
    end else if (above_sel) begin
      boost_run <= 1'b0;
    end
  end

  // Activation sets the flag; a clear is honoured only above the threshold.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_up_active_flag <= 1'b0;
    end else if (boost_ok && below_sel && !boost_run) begin
      step_up_active_flag <= 1'b1;
    end else if (wr_en && (paddr == SMC_ADDR_STAT) && pwdata[SMC_ST_ACT] && !below_sel) begin
      step_up_active_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Automatic PFM to PWM switch in Stop on overload, cleared by a Stop command or entry.
  assign auto_hit = (mode == SMC_STOP) && hardware_control[SMC_HW_AUTO_OK] &&
                    buck_load_high && !auto_pwm;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_pwm              <= 1'b0;
      auto_transition_event <= 1'b0;
    end else begin
      auto_transition_event <= auto_hit;
      if (mode != SMC_STOP || stop_entry || stop_cmd) begin
        auto_pwm <= 1'b0;
      end else if (auto_hit) begin
        auto_pwm <= 1'b1;
      end
    end
  end

  // Wake status flag: hardware set wins over a software clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_transition_flag <= 1'b0;
    end else begin
      auto_transition_flag <= auto_hit ||
                              (auto_transition_flag &&
                               !(wr_en && (paddr == SMC_ADDR_WKSTAT) && pwdata[SMC_WK_AUTO]));
    end
  end

  // Buck modulation per mode; the wake pin is taken unfiltered by design.
  always_comb begin
    case (mode)
      SMC_NORMAL:  next_pwm = 1'b1;
      SMC_RESTART: next_pwm = 1'b1;
      SMC_STOP:    next_pwm = !stop_entry && (auto_pwm ||
                              (hardware_control[SMC_HW_WAKE_MOD] && wake_input_pin));
      default:     next_pwm = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smps_enable          <= 1'b0;
      buck_pwm             <= 1'b0;
      buck_full_duty_allow <= 1'b0;
    end else begin
      smps_enable          <= supply_mode;
      buck_pwm             <= next_pwm && supply_mode;
      buck_full_duty_allow <= next_pwm && supply_mode && !soft_start_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Soft start sequencer.
  smc_soft_start u_soft_start (
    .pclk           (pclk),
    .presetn        (presetn),
    .start          (ss_start),
    .sw_tick        (sw_tick),
    .target_reached (buck_target_reached),
    .active         (soft_start_active),
    .duty           (buck_duty)
  );

endmodule
`default_nettype wire

// ---- verif/smc_props.sv ----
// Concurrent checks on the supply mode controller ports.
`timescale 1ns/1ns
`default_nettype none
module smc_props
  import smc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [2:0]  sys_mode,
  input wire logic        sense_below_th1,
  input wire logic        sense_below_th2,
  input wire logic        smps_enable,
  input wire logic        buck_pwm,
  input wire logic [7:0]  buck_duty,
  input wire logic        soft_start_active,
  input wire logic        boost_run,
  input wire logic        step_up_active_flag,
  input wire logic        auto_transition_event,
  input wire logic        wake_timer_tick
);
  //////////////////////////////////////////////////////////////////////////////
  // Decode helpers; both comparators are used because the select bit is not a port.
  logic mapped;
  logic both_below;
  assign mapped     = paddr inside {SMC_ADDR_TIMER, SMC_ADDR_HWCTL, SMC_ADDR_MODE,
                                    SMC_ADDR_STAT, SMC_ADDR_WKSTAT, SMC_ADDR_SSTAT};
  assign both_below = sense_below_th1 && sense_below_th2;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  //////////////////////////////////////////////////////////////////////////////
  // Bus answer timing and refusal.
  a_pready_access: assert property (psel && !penable |=> pready) else $error("pready late");
  a_pready_once: assert property (pready |-> $past(psel) && !$past(penable)) else $error("pready stray");
  a_slverr_map: assert property (pready |-> pslverr == !mapped) else $error("pslverr wrong");
  a_idle_zero: assert property (!pready |-> !pslverr && prdata == 32'h0) else $error("bus not idle");

  // Mode gating and buck modulation.
  a_enable_mode: assert property ($past(presetn) |->
    smps_enable == ($past(sys_mode) inside {SMC_NORMAL, SMC_STOP, SMC_RESTART})) else $error("enable wrong");
  a_sleep_off: assert property ((sys_mode == SMC_SLEEP || sys_mode == SMC_FAILSAFE)[*3]
    |=> !boost_run && !smps_enable) else $error("supply on in sleep");
  a_normal_pwm: assert property ((sys_mode == SMC_NORMAL)[*2] |=> buck_pwm) else $error("no pwm");
  a_stop_pfm: assert property (sys_mode == SMC_STOP && $past(sys_mode) != SMC_STOP
    |=> !buck_pwm) else $error("no pfm on stop");
  a_event_pulse: assert property (auto_transition_event
    |-> $past(sys_mode) == SMC_STOP ##1 !auto_transition_event) else $error("bad event");
  a_tick_pulse: assert property (wake_timer_tick |=> !wake_timer_tick) else $error("long tick");

  // Boost flag and soft start ramp.
  a_flag_set: assert property ($rose(boost_run) |-> ##[0:1] step_up_active_flag) else $error("no flag");
  a_flag_hold: assert property ($fell(step_up_active_flag) |->
    !($past(both_below, 2) && $past(both_below, 3) && $past(both_below, 4))) else $error("flag cleared");
  a_duty_step: assert property (soft_start_active && $past(soft_start_active) && $changed(buck_duty)
    |-> buck_duty == $past(buck_duty) + SMC_SS_STEP || buck_duty == SMC_SS_FULL) else $error("bad step");
  a_ss_min: assert property (soft_start_active |-> buck_duty >= SMC_SS_MIN) else $error("duty low");
endmodule

bind smc_top smc_props u_props (
  .pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready, .pslverr, .sys_mode,
  .sense_below_th1, .sense_below_th2, .smps_enable, .buck_pwm, .buck_duty, .soft_start_active,
  .boost_run, .step_up_active_flag, .auto_transition_event, .wake_timer_tick
);
`default_nettype wire

// ---- verif/smc_power_model.sv ----
// Behavioural analog stage: supply comparators and buck output level.
`timescale 1ns/1ns
`default_nettype none
module smc_power_model #(
  parameter int TH1  = 60,
  parameter int HYS1 = 10,
  parameter int TH2  = 80,
  parameter int HYS2 = 10,
  parameter int GOAL = 16
)
(
  input  wire logic [7:0] supply_level,
  input  wire logic       smps_enable,
  input  wire logic [7:0] buck_duty,
  output logic            sense_below_th1,
  output logic            sense_above_hys1,
  output logic            sense_below_th2,
  output logic            sense_above_hys2,
  output logic            buck_target_reached
);
  // Comparators follow the supply at once, so a slow design sync shows up as lag.
  assign sense_below_th1  = supply_level < TH1;
  assign sense_above_hys1 = supply_level > TH1 + HYS1;
  assign sense_below_th2  = supply_level < TH2;
  assign sense_above_hys2 = supply_level > TH2 + HYS2;

  // The output only counts as settled while powered, so a restart from Sleep or Fail-Safe must ramp again.
  assign buck_target_reached = smps_enable && buck_duty >= GOAL;
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the supply mode controller.
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import smc_pkg::*;
;
  //////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals.
  localparam int MSD = 10;
  logic        pclk, presetn, psel, penable, pwrite, buck_load_high, wake_input_pin, wk;
  logic [7:0]  paddr, bat, duty;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  sys_mode;
  logic [5:0]  flt, f;
  logic        pready, pslverr, err, en, pwm, fda, ssa, run, flag, evt, tick, tgt;
  logic        sense_below_th1, sense_above_hys1, sense_below_th2, sense_above_hys2;
  int          bad_count, n_tests, evts, n, seed;
  logic [7:0]  ra [5] = '{SMC_ADDR_TIMER, SMC_ADDR_HWCTL, SMC_ADDR_STAT, SMC_ADDR_WKSTAT, 8'h18};
  int          per [7] = '{10, 20, 50, 100, 200, 1000, 2000};

  smc_top #(.MS_DIV(MSD)) dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sys_mode, .buck_load_high, .buck_target_reached(tgt), .wake_input_pin, .sense_below_th1,
    .sense_above_hys1, .sense_below_th2, .sense_above_hys2, .buck_node_open(flt[0]),
    .buck_node_short(flt[1]), .buck_out_of_band(flt[2]), .boost_pin_open(flt[3]),
    .boost_pin_short(flt[4]), .boost_gnd_lost(flt[5]), .smps_enable(en), .buck_pwm(pwm),
    .buck_full_duty_allow(fda), .buck_duty(duty), .soft_start_active(ssa), .boost_run(run),
    .step_up_active_flag(flag), .auto_transition_event(evt), .wake_timer_tick(tick)
  );
  smc_power_model model_u (
    .supply_level(bat), .smps_enable(en), .buck_duty(duty), .sense_below_th1, .sense_above_hys1,
    .sense_below_th2, .sense_above_hys2, .buck_target_reached(tgt)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Shared tasks.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  // The request is held until pready is sampled high; no slave latency is assumed.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ss_done;
    n = 0;
    while (ssa === 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    cyc(2);
    check(ssa, 0);
    check(fda, 1);
  endtask
  task automatic next_tick;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (tick !== 1'b1 && n < 30000);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Clock, event counter and watchdog; the timer sweep alone needs about 68000 cycles.
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) if (evt === 1'b1) evts <= evts + 1;
  initial begin
    repeat (95000) @(posedge pclk);
    bad_count++;
    final_report();
  end

  // Main sequence.
  initial begin
    {presetn, psel, penable, pwrite, buck_load_high, wake_input_pin} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sys_mode = SMC_NORMAL;
    flt = 6'h0;
    bat = 8'h64;
    evts = 0;
    seed = $urandom(32'hb0349f4e);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    cyc(2);
    check(ssa, 1);
    check(duty, SMC_SS_MIN);
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      check(rd, (i == 1) ? SMC_HW_RESET : 4'h0);
      check(err, i == 4);
    end
    ss_done();
    $display("reset test done");
    for (int m = 0; m < 5; m++) begin
      sys_mode <= 3'(m);
      cyc(3);
      check(en, m < 3);
      if (m < 3) check(pwm, m != 1);
      if (m > 2) begin
        sys_mode <= SMC_RESTART;
        cyc(3);
        check(ssa, 1);
        ss_done();
      end
    end
    $display("mode test done");
    sys_mode <= SMC_STOP;
    cyc(3);
    buck_load_high <= 1'b1;
    cyc(3);
    check(pwm, 1);
    check(evts, 1);
    apb(1'b0, SMC_ADDR_WKSTAT, 32'h0);
    check(rd, 1);
    buck_load_high <= 1'b0;
    apb(1'b1, SMC_ADDR_MODE, 32'h1);
    apb(1'b1, SMC_ADDR_WKSTAT, 32'h1);
    cyc(2);
    check(pwm, 0);
    apb(1'b1, SMC_ADDR_HWCTL, 32'h0);
    buck_load_high <= 1'b1;
    cyc(4);
    check(pwm, 0);
    check(evts, 1);
    buck_load_high <= 1'b0;
    apb(1'b1, SMC_ADDR_HWCTL, 32'h8);
    repeat (4) begin
      wk = 1'($urandom);
      wake_input_pin <= wk;
      cyc(3);
      check(pwm, wk);
    end
    apb(1'b1, SMC_ADDR_HWCTL, 32'h0);
    cyc(2);
    check(pwm, 0);
    $display("stop test done");
    sys_mode <= SMC_NORMAL;
    apb(1'b1, SMC_ADDR_HWCTL, 32'h7);
    bat <= 8'h32;
    cyc(5);
    check(run, 1);
    check(flag, 1);
    apb(1'b1, SMC_ADDR_STAT, 32'h40);
    cyc(1);
    check(flag, 1);
    bat <= 8'h41;
    cyc(5);
    check(run, 1);
    bat <= 8'h4b;
    cyc(5);
    check(run, 0);
    apb(1'b1, SMC_ADDR_STAT, 32'h40);
    cyc(1);
    check(flag, 0);
    apb(1'b1, SMC_ADDR_HWCTL, 32'h5);
    cyc(5);
    check(run, 1);
    apb(1'b0, SMC_ADDR_STAT, 32'h0);
    check(rd[7:6], 2'b11);
    bat <= 8'h64;
    cyc(5);
    check(run, 0);
    apb(1'b1, SMC_ADDR_HWCTL, 32'h0);
    sys_mode <= SMC_SLEEP;
    cyc(2);
    apb(1'b1, SMC_ADDR_HWCTL, 32'h1);
    apb(1'b0, SMC_ADDR_HWCTL, 32'h0);
    check(rd, 0);
    sys_mode <= SMC_NORMAL;
    $display("boost test done");
    repeat (4) begin
      f = 6'($urandom);
      flt <= f;
      cyc(3);
      apb(1'b0, SMC_ADDR_STAT, 32'h0);
      check(rd[5:0], f);
      check(en, 1);
      check(pwm, 1);
      flt <= 6'h0;
      apb(1'b1, SMC_ADDR_STAT, 32'h3f);
      apb(1'b0, SMC_ADDR_STAT, 32'h0);
      check(rd[5:0], 6'h0);
    end
    $display("status test done");
    for (int c = 0; c < 7; c++) begin
      apb(1'b1, SMC_ADDR_TIMER, 32'(8 + c));
      next_tick();
      next_tick();
      check(n, per[c] * MSD);
    end
    apb(1'b1, SMC_ADDR_TIMER, 32'h0);
    $display("timer test done");
    final_report();
  end
endmodule
`default_nettype wire
